/* logic/pwm_cycle_config.sv */
`timescale 1ns/1ps
// ************************************************************
// PWM cycle configuration slice of the counter array
// ************************************************************
module pwm_cycle_config (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Special-function register bus
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdData,
  // Normal compare registers outside this slice
  input wire logic [7:0] normCmpRdData,
  output logic normCmpWr,
  output logic normCmpRd,
  // Main counter and channel modes
  input wire logic [15:0] counterValue,
  input wire logic counterTick,
  input wire logic [pwm_cycle_pkg::NUM_CHAN-1:0] chanPwmEnable,
  input wire logic [pwm_cycle_pkg::NUM_CHAN-1:0] widePwmSelect,
  // Per-channel results
  output logic [pwm_cycle_pkg::NUM_CHAN-1:0][15:0] reloadValue,
  output logic [pwm_cycle_pkg::NUM_CHAN-1:0] reloadActive,
  output logic [pwm_cycle_pkg::NUM_CHAN-1:0][4:0] chanCycleBits,
  // Shared configuration and interrupt
  output pwm_cycle_pkg::cycle_len_t cycleLengthSelect,
  output logic reloadRegSelect,
  output logic cycleOverflowIrqEn,
  output logic cycleOverflowFlag,
  output logic progCounterArrayIrq
);
  import pwm_cycle_pkg::*;

  // ************************************************************
  // Address decode
  // ************************************************************
  logic cfgHit;
  logic cmpHit;
  logic [7:0] cmpOffset;
  logic [2:0] cmpChan;
  logic cmpHigh;
  logic cfgWr;

  // Offset math wraps below the base, so the lower bound is checked too
  assign cmpOffset = sfrAddr - CMP_BASE_ADDR;
  assign cmpHit = (sfrAddr >= CMP_BASE_ADDR) && (cmpOffset < CMP_SPAN);
  assign cmpChan = cmpOffset[3:1];
  assign cmpHigh = cmpOffset[0];
  assign cfgHit = (sfrAddr == CFG_ADDR);
  assign cfgWr = sfrWr && cfgHit;

  // Normal compare registers only see traffic while reload select is clear
  assign normCmpWr = sfrWr && cmpHit && !reloadRegSelect;
  assign normCmpRd = sfrRd && cmpHit && !reloadRegSelect;

  // ************************************************************
  // Configuration register
  // ************************************************************
  logic next_reloadRegSelect;
  logic next_cycleOverflowIrqEn;
  logic next_cycleOverflowFlag;
  cycle_len_t next_cycleLengthSelect;
  logic [10:0] wrapMask;
  logic cycleWrap;

  // Low bits of the counter that make up one narrow cycle
  assign wrapMask = MAX_CYCLE_MASK >> (2'h3 - cycleLengthSelect);
  // Overflow out of the selected bit: all selected bits set on a tick
  assign cycleWrap = counterTick && ((counterValue[10:0] & wrapMask) == wrapMask);

  // Next values of the stored configuration fields
  always_comb begin
    next_reloadRegSelect = reloadRegSelect;
    next_cycleOverflowIrqEn = cycleOverflowIrqEn;
    next_cycleLengthSelect = cycleLengthSelect;
    next_cycleOverflowFlag = cycleOverflowFlag;
    if (cfgWr) begin
      // Bits 4:2 have no storage, so writes there vanish
      next_reloadRegSelect = sfrWrData[RELOAD_SEL_BIT];
      next_cycleOverflowIrqEn = sfrWrData[IRQ_EN_BIT];
      next_cycleLengthSelect = cycle_len_t'(sfrWrData[CLSEL_MSB:CLSEL_LSB]);
      next_cycleOverflowFlag = sfrWrData[OVF_FLAG_BIT];
    end
    // Overflow set last so it beats a clearing write in the same cycle
    if (cycleWrap) begin
      next_cycleOverflowFlag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reloadRegSelect <= CFG_RESET[RELOAD_SEL_BIT];
      cycleOverflowIrqEn <= CFG_RESET[IRQ_EN_BIT];
      cycleOverflowFlag <= CFG_RESET[OVF_FLAG_BIT];
      cycleLengthSelect <= cycle_len_t'(CFG_RESET[CLSEL_MSB:CLSEL_LSB]);
    end else begin
      reloadRegSelect <= next_reloadRegSelect;
      cycleOverflowIrqEn <= next_cycleOverflowIrqEn;
      cycleOverflowFlag <= next_cycleOverflowFlag;
      cycleLengthSelect <= next_cycleLengthSelect;
    end
  end

  // Masked flag onto the shared array request
  assign progCounterArrayIrq = cycleOverflowFlag && cycleOverflowIrqEn;

  // ************************************************************
  // Per-channel reload slices
  // ************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : gChan
      logic chanHit;
      // Reload bytes are written only while reload select is set
      assign chanHit = sfrWr && cmpHit && reloadRegSelect && (cmpChan == 3'(ch));
      chan_reload_slice uSlice (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrLow(chanHit && !cmpHigh),
        .wrHigh(chanHit && cmpHigh),
        .wrData(sfrWrData),
        .pwmEnable(chanPwmEnable[ch]),
        .widePwmSelect(widePwmSelect[ch]),
        .cycleLengthSelect(cycleLengthSelect),
        .reloadValue(reloadValue[ch]),
        .reloadActive(reloadActive[ch]),
        .cycleBits(chanCycleBits[ch])
      );
    end
  endgenerate

  // ************************************************************
  // Read data
  // ************************************************************
  logic [7:0] next_sfrRdData;
  logic [15:0] selReload;

  assign selReload = (cmpChan < 3'(NUM_CHAN)) ? reloadValue[cmpChan] : RELOAD_RESET;

  // Registered answer; unmapped addresses read zero
  always_comb begin
    next_sfrRdData = sfrRdData;
    if (sfrRd) begin
      next_sfrRdData = RDATA_RESET;
      if (cfgHit) begin
        next_sfrRdData[RELOAD_SEL_BIT] = reloadRegSelect;
        next_sfrRdData[IRQ_EN_BIT] = cycleOverflowIrqEn;
        next_sfrRdData[OVF_FLAG_BIT] = cycleOverflowFlag;
        next_sfrRdData[CLSEL_MSB:CLSEL_LSB] = cycleLengthSelect; // bits 4:2 stay zero
      end else if (cmpHit && reloadRegSelect) begin
        next_sfrRdData = cmpHigh ? selReload[15:8] : selReload[7:0];
      end else if (cmpHit) begin
        next_sfrRdData = normCmpRdData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfrRdData <= RDATA_RESET;
    end else begin
      sfrRdData <= next_sfrRdData;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_reloadLowWrite;
    sfrWr && cmpHit && reloadRegSelect && !cmpHigh;
  endsequence

  sequence s_cfgRead;
    sfrRd && cfgHit;
  endsequence

  sequence s_clearRace;
    cycleWrap && cfgWr && !sfrWrData[OVF_FLAG_BIT];
  endsequence

  property p_reload_route;
    sfrWr && cmpHit |-> (normCmpWr == !reloadRegSelect);
  endproperty
  a_reload_route: assert property (p_reload_route) else $error("compare write misrouted");

  property p_reload_lands;
    s_reloadLowWrite |=> reloadValue[$past(cmpChan)][7:0] == $past(sfrWrData);
  endproperty
  a_reload_lands: assert property (p_reload_lands) else $error("reload byte not stored");

  property p_reload_idle;
    !(chanPwmEnable[0] && !widePwmSelect[0] && cycleLengthSelect != CYC_8) |-> !reloadActive[0];
  endproperty
  a_reload_idle: assert property (p_reload_idle) else $error("reload active wrongly");

  property p_irq_mask;
    $rose(cycleOverflowFlag) |-> (progCounterArrayIrq == cycleOverflowIrqEn);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt does not follow mask");

  property p_wrap8;
    counterTick && cycleLengthSelect == CYC_8 && counterValue[7:0] == 8'hFF |=> cycleOverflowFlag;
  endproperty
  a_wrap8: assert property (p_wrap8) else $error("8-bit overflow not flagged");

  property p_wrap11_only;
    cycleLengthSelect == CYC_11 && counterTick && counterValue[10:0] != 11'h7FF
      && !cycleOverflowFlag && !cfgWr |=> !cycleOverflowFlag;
  endproperty
  a_wrap11_only: assert property (p_wrap11_only) else $error("early 11-bit flag");

  property p_sticky;
    cycleOverflowFlag && !cfgWr |=> cycleOverflowFlag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by itself");

  // Channel 1 is the narrow one in normal use, channel 0 the wide one
  property p_len_map;
    !widePwmSelect[1] |-> chanCycleBits[1] == 5'(8 + cycleLengthSelect);
  endproperty
  a_len_map: assert property (p_len_map) else $error("wrong cycle length");

  property p_wide;
    widePwmSelect[0] |-> chanCycleBits[0] == 5'h10;
  endproperty
  a_wide: assert property (p_wide) else $error("wide channel not 16 bits");

  property p_reserved;
    s_cfgRead |=> sfrRdData[4:2] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("unused bits read nonzero");

  property p_set_wins;
    s_clearRace |=> cycleOverflowFlag ##1 (cycleOverflowFlag || $past(cfgWr));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat overflow");

endmodule

/* logic/pwm_cycle_pkg.sv */
// ************************************************************
// Shared constants for the PWM cycle configuration slice
// ************************************************************
package pwm_cycle_pkg;

  // Channel count of the counter array
  localparam int NUM_CHAN = 6;

  // Configuration register address on the special-function bus
  localparam logic [7:0] CFG_ADDR = 8'hDF;

  // Compare bytes: low byte at base + 2n, high byte at base + 2n + 1
  localparam logic [7:0] CMP_BASE_ADDR = 8'hA0;
  localparam logic [7:0] CMP_SPAN = 8'h0C;

  // Configuration field positions
  localparam int RELOAD_SEL_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int OVF_FLAG_BIT = 5;
  localparam int CLSEL_MSB = 1;
  localparam int CLSEL_LSB = 0;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Cycle widths in counter bits
  localparam logic [4:0] BASE_CYCLE_BITS = 5'h08;
  localparam logic [4:0] WIDE_CYCLE_BITS = 5'h10;
  localparam logic [10:0] MAX_CYCLE_MASK = 11'h7FF;

  // Cycle length codes, in order 8, 9, 10, 11 bits
  typedef enum logic [1:0] {CYC_8, CYC_9, CYC_10, CYC_11} cycle_len_t;

endpackage

/* logic/chan_reload_slice.sv */
`timescale 1ns/1ps
// ************************************************************
// One channel: auto-reload value and cycle width
// ************************************************************
module chan_reload_slice (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Byte writes steered to this channel's reload value
  input wire logic wrLow,
  input wire logic wrHigh,
  input wire logic [7:0] wrData,
  // Channel mode and shared cycle length
  input wire logic pwmEnable,
  input wire logic widePwmSelect,
  input wire pwm_cycle_pkg::cycle_len_t cycleLengthSelect,
  // Results
  output logic [15:0] reloadValue,
  output logic reloadActive,
  output logic [4:0] cycleBits
);
  import pwm_cycle_pkg::*;

  logic [15:0] next_reloadValue;

  // Byte-wise update of the held reload value
  always_comb begin
    next_reloadValue = reloadValue;
    if (wrLow) begin
      next_reloadValue[7:0] = wrData;
    end
    if (wrHigh) begin
      next_reloadValue[15:8] = wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reloadValue <= RELOAD_RESET;
    end else begin
      reloadValue <= next_reloadValue;
    end
  end

  // Reload only matters for 9 to 11 bit narrow PWM
  assign reloadActive = pwmEnable && !widePwmSelect && (cycleLengthSelect != CYC_8);

  // Wide channels ignore the shared length field entirely
  assign cycleBits = widePwmSelect ? WIDE_CYCLE_BITS :
                     (BASE_CYCLE_BITS + {3'h0, cycleLengthSelect});

endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import pwm_cycle_pkg::*;
  logic clk, sysRst, sfrWr, sfrRd, counterTick;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, normCmpRdData, rdVal;
  logic normCmpWr, normCmpRd, lastNormWr, lastNormRd;
  logic [15:0] counterValue, mask;
  logic [NUM_CHAN-1:0] chanPwmEnable, widePwmSelect, reloadActive;
  logic [NUM_CHAN-1:0][15:0] reloadValue;
  logic [NUM_CHAN-1:0][4:0] chanCycleBits;
  cycle_len_t cycleLengthSelect;
  logic reloadRegSelect, cycleOverflowIrqEn, cycleOverflowFlag, progCounterArrayIrq;
  int fails, totalChecks;

  pwm_cycle_config uut (.clk(clk), .sys_rst(sysRst), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData),
    .normCmpRdData(normCmpRdData), .normCmpWr(normCmpWr), .normCmpRd(normCmpRd),
    .counterValue(counterValue), .counterTick(counterTick), .chanPwmEnable(chanPwmEnable),
    .widePwmSelect(widePwmSelect), .reloadValue(reloadValue), .reloadActive(reloadActive),
    .chanCycleBits(chanCycleBits), .cycleLengthSelect(cycleLengthSelect),
    .reloadRegSelect(reloadRegSelect), .cycleOverflowIrqEn(cycleOverflowIrqEn),
    .cycleOverflowFlag(cycleOverflowFlag), .progCounterArrayIrq(progCounterArrayIrq));

  // ************************************************************
  // Clock and bus tasks
  // ************************************************************
  // Free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compare and count; four-state compare so an unknown matches only an unknown
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; steering output sampled while strobe is up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrWr <= 1'b1;
    sfrAddr <= a;
    sfrWrData <= d;
    #1 lastNormWr = normCmpWr;
    @(posedge clk);
    sfrWr <= 1'b0;
    #1;
  endtask

  // Read answer is registered on the edge that takes the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sfrRd <= 1'b1;
    sfrAddr <= a;
    #1 lastNormRd = normCmpRd;
    @(posedge clk);
    sfrRd <= 1'b0;
    #1 rdVal = sfrRdData;
  endtask

  // Counter advance with a given pre-increment value
  task automatic tick(input logic [15:0] v);
    @(posedge clk);
    counterValue <= v;
    counterTick <= 1'b1;
    @(posedge clk);
    counterTick <= 1'b0;
    #1;
  endtask

  task automatic endOfTest();
    if (fails == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    sysRst = 1'b1;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    normCmpRdData = 8'h3C;
    counterValue = 16'h0000;
    counterTick = 1'b0;
    // Ch0 wide PWM, ch5 wide but not PWM: mixes every mode combination except narrow without PWM
    chanPwmEnable = 6'h1F;
    widePwmSelect = 6'h21;
    fails = 0;
    totalChecks = 0;
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    rd(CFG_ADDR);
    chk(rdVal, 16'h0000);
    wr(CFG_ADDR, 8'h7C);
    rd(CFG_ADDR);
    chk(rdVal, 16'h0060);
    chk(cycleOverflowIrqEn, 1'b1);
    chk(progCounterArrayIrq, 1'b1);
    wr(CFG_ADDR, 8'h20);
    chk(progCounterArrayIrq, 1'b0);
    wr(CFG_ADDR, 8'h40);
    chk(cycleOverflowFlag, 1'b0);
    // Each length code: a lower bit's overflow must not set the flag
    for (int s = 0; s < 4; s++) begin
      wr(CFG_ADDR, 8'h40 | 8'(s));
      chk(cycleLengthSelect, 16'(s));
      mask = (16'h0001 << (8 + s)) - 16'h0001;
      tick(mask >> 1);
      chk(cycleOverflowFlag, 1'b0);
      for (int c = 0; c < NUM_CHAN; c++) begin
        chk(chanCycleBits[c], widePwmSelect[c] ? 16'h0010 : 16'(8 + s));
        chk(reloadActive[c], chanPwmEnable[c] & ~widePwmSelect[c] & (s != 0));
      end
      tick(mask | 16'hF000);
      chk(cycleOverflowFlag, 1'b1);
      chk(progCounterArrayIrq, 1'b1);
      tick(16'h0000);
      chk(cycleOverflowFlag, 1'b1);
      wr(CFG_ADDR, 8'h40 | 8'(s));
      chk(cycleOverflowFlag, 1'b0);
    end
    // Clearing write meets an overflow at the same edge: set wins
    @(posedge clk);
    sfrWr <= 1'b1;
    sfrAddr <= CFG_ADDR;
    sfrWrData <= 8'h00;
    counterValue <= 16'h07FF;
    counterTick <= 1'b1;
    @(posedge clk);
    sfrWr <= 1'b0;
    counterTick <= 1'b0;
    #1 chk(cycleOverflowFlag, 1'b1);
    chk(progCounterArrayIrq, 1'b0);
    // Compare addresses steered to normal registers, then to reloads
    wr(CMP_BASE_ADDR + 8'h02, 8'h5A);
    chk(lastNormWr, 1'b1);
    chk(reloadValue[1], 16'h0000);
    rd(CMP_BASE_ADDR + 8'h02);
    chk(lastNormRd, 1'b1);
    chk(rdVal, 16'h003C);
    wr(CFG_ADDR, 8'h80);
    chk(reloadRegSelect, 1'b1);
    chk(cycleOverflowIrqEn, 1'b0);
    wr(CMP_BASE_ADDR + 8'h03, 8'hA5);
    chk(lastNormWr, 1'b0);
    wr(CMP_BASE_ADDR + 8'h02, 8'h5A);
    chk(reloadValue[1], 16'hA55A);
    wr(CMP_BASE_ADDR + 8'h0B, 8'h77);
    chk(reloadValue[5], 16'h7700);
    rd(CMP_BASE_ADDR + 8'h03);
    chk(lastNormRd, 1'b0);
    chk(rdVal, 16'h00A5);
    // Outside both maps: neither compare nor reload data comes back
    rd(8'h10);
    chk(rdVal, 16'h0000);
    endOfTest();
  end
endmodule
